/* logic/switch_mode_sequencer_leds.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mode_seq_cfg.svh"
module switch_mode_sequencer_leds #(
   parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES,
   parameter logic [7:0] TIMEOUT_TICKS = `SWITCH_TIMEOUT_TICKS
)
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic switch_input_pin_in,
   input wire logic xtal_ready_in,
   output logic [4:0] led_out,
   output logic error_out,
   output logic done_halt_out,
   output logic [7:0] boot_option_out,
   output logic [5:0] fast_osc_mhz_out,
   output logic [1:0] clk_src_out,
   output logic [1:0] op_mode_out
);
   // ------------------------------------------------------------
   // step table
   // ------------------------------------------------------------
   function automatic mode_seq_pkg::step_t step_of(input logic [4:0] idx);
      mode_seq_pkg::step_t s;
      unique case (idx)
         5'h00:
         begin
            s = '{mode_seq_pkg::src_fast, mode_seq_pkg::op_normal};
         end
         5'h01:
         begin
            s = '{mode_seq_pkg::src_xtal, mode_seq_pkg::op_normal};
         end
         5'h02:
         begin
            s = '{mode_seq_pkg::src_xtal, mode_seq_pkg::op_halt};
         end
         5'h03:
         begin
            s = '{mode_seq_pkg::src_xtal, mode_seq_pkg::op_normal};
         end
         5'h04:
         begin
            s = '{mode_seq_pkg::src_xtal, mode_seq_pkg::op_stop};
         end
         5'h05:
         begin
            s = '{mode_seq_pkg::src_xtal, mode_seq_pkg::op_normal};
         end
         5'h06:
         begin
            s = '{mode_seq_pkg::src_fast, mode_seq_pkg::op_normal};
         end
         5'h07:
         begin
            s = '{mode_seq_pkg::src_fast, mode_seq_pkg::op_halt};
         end
         5'h08:
         begin
            s = '{mode_seq_pkg::src_fast, mode_seq_pkg::op_normal};
         end
         5'h09:
         begin
            s = '{mode_seq_pkg::src_fast, mode_seq_pkg::op_stop};
         end
         5'h0a:
         begin
            s = '{mode_seq_pkg::src_fast, mode_seq_pkg::op_normal};
         end
         5'h0b:
         begin
            s = '{mode_seq_pkg::src_fast, mode_seq_pkg::op_snooze};
         end
         5'h0c:
         begin
            s = '{mode_seq_pkg::src_fast, mode_seq_pkg::op_normal};
         end
         5'h0d:
         begin
            s = '{mode_seq_pkg::src_mid, mode_seq_pkg::op_normal};
         end
         5'h0e:
         begin
            s = '{mode_seq_pkg::src_xtal, mode_seq_pkg::op_normal};
         end
         5'h0f:
         begin
            s = '{mode_seq_pkg::src_low, mode_seq_pkg::op_normal};
         end
         5'h10:
         begin
            s = '{mode_seq_pkg::src_xtal, mode_seq_pkg::op_normal};
         end
         5'h11:
         begin
            s = '{mode_seq_pkg::src_mid, mode_seq_pkg::op_normal};
         end
         5'h12:
         begin
            s = '{mode_seq_pkg::src_mid, mode_seq_pkg::op_halt};
         end
         5'h13:
         begin
            s = '{mode_seq_pkg::src_mid, mode_seq_pkg::op_normal};
         end
         5'h14:
         begin
            s = '{mode_seq_pkg::src_mid, mode_seq_pkg::op_stop};
         end
         5'h15:
         begin
            s = '{mode_seq_pkg::src_mid, mode_seq_pkg::op_normal};
         end
         5'h16:
         begin
            s = '{mode_seq_pkg::src_mid, mode_seq_pkg::op_snooze};
         end
         5'h17:
         begin
            s = '{mode_seq_pkg::src_mid, mode_seq_pkg::op_normal};
         end
         5'h18:
         begin
            s = '{mode_seq_pkg::src_low, mode_seq_pkg::op_normal};
         end
         5'h19:
         begin
            s = '{mode_seq_pkg::src_mid, mode_seq_pkg::op_normal};
         end
         5'h1a:
         begin
            s = '{mode_seq_pkg::src_fast, mode_seq_pkg::op_normal};
         end
         5'h1b:
         begin
            s = '{mode_seq_pkg::src_low, mode_seq_pkg::op_normal};
         end
         5'h1c:
         begin
            s = '{mode_seq_pkg::src_low, mode_seq_pkg::op_halt};
         end
         5'h1d:
         begin
            s = '{mode_seq_pkg::src_low, mode_seq_pkg::op_normal};
         end
         5'h1e:
         begin
            s = '{mode_seq_pkg::src_fast, mode_seq_pkg::op_normal};
         end
         default: s = '{mode_seq_pkg::src_fast, mode_seq_pkg::op_normal};
      endcase
      return s;
   endfunction

   function automatic logic [4:0] leds_of(input mode_seq_pkg::step_t s);
      logic [4:0] p;
      p = 5'h00;
      // bit0 is indicator_one, bit4 the fifth LED
      unique case (s.src) // [R3]
         mode_seq_pkg::src_fast: p = 5'h13;
         mode_seq_pkg::src_xtal: p = 5'h17;
         mode_seq_pkg::src_mid: p = 5'h0b;
         mode_seq_pkg::src_low: p = 5'h1b;
      endcase
      unique case (s.mode) // [R4]
         mode_seq_pkg::op_normal: p = p;
         mode_seq_pkg::op_halt: p = p & 5'h1e;
         mode_seq_pkg::op_stop: p = p & 5'h1c;
         mode_seq_pkg::op_snooze: p = p & 5'h1d;
      endcase
      return p;
   endfunction

   // ------------------------------------------------------------
   // sample tick and debounce
   // ------------------------------------------------------------
   logic [31:0] tick_cnt_q;
   logic tick;
   logic samp_a_q;
   logic samp_b_q;
   logic stable_q;
   logic press;
   assign tick = (tick_cnt_q == 32'(SAMPLE_CYCLES - 1));

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         tick_cnt_q <= 32'h0;
      else if (tick)
         tick_cnt_q <= 32'h0;
      else
         tick_cnt_q <= tick_cnt_q + 32'h1; // [R2]
   end

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         samp_a_q <= 1'b1;
         samp_b_q <= 1'b1;
         stable_q <= 1'b1;
      end
      else if (tick)
      begin
         samp_a_q <= switch_input_pin_in;
         samp_b_q <= samp_a_q;
         if (samp_a_q == samp_b_q) // [R2]
            stable_q <= samp_a_q;
      end
   end

   // confirmed falling edge only; bounce never reaches the stepper
   assign press = tick && (samp_a_q == samp_b_q) && stable_q && !samp_a_q; // [R9] [R11] [R1]

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   typedef enum logic [1:0] {st_run, st_switch, st_done, st_error} seq_state_t;
   seq_state_t state_q;
   logic [4:0] step_q;
   logic [7:0] wait_q;
   mode_seq_pkg::step_t cur;
   mode_seq_pkg::step_t nxt;
   assign cur = step_of(step_q);
   assign nxt = step_of(step_q + 5'h1);

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         state_q <= st_run;
         step_q <= 5'h00; // [R8]
         wait_q <= 8'h00;
      end
      else
      begin
         unique case (state_q)
            st_run:
               if (press)
               begin
                  if (step_q == 5'(`STEP_COUNT - 1))
                     state_q <= st_done; // [R5]
                  else if (nxt.src == mode_seq_pkg::src_xtal && cur.src != mode_seq_pkg::src_xtal
                           && !xtal_ready_in)
                  begin
                     state_q <= st_switch;
                     wait_q <= 8'h00;
                  end
                  else
                     step_q <= step_q + 5'h1; // [R1]
               end
            st_switch:
               if (xtal_ready_in)
               begin
                  step_q <= step_q + 5'h1;
                  state_q <= st_run;
               end
               else if (tick)
               begin
                  if (wait_q == TIMEOUT_TICKS - 8'h1)
                     state_q <= st_error; // [R6]
                  else
                     wait_q <= wait_q + 8'h1;
               end
            st_done: state_q <= st_done; // [R5]
            st_error: state_q <= st_error; // [R6]
         endcase
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         led_out <= `LED_RESET;
         error_out <= 1'b0;
         done_halt_out <= 1'b0;
         clk_src_out <= 2'h0;
         op_mode_out <= 2'h0;
      end
      else
      begin
         led_out <= (state_q == st_done || state_q == st_error) ? 5'h00 : leds_of(cur); // [R7] [R5] [R6]
         error_out <= (state_q == st_error);
         done_halt_out <= (state_q == st_done);
         clk_src_out <= cur.src;
         op_mode_out <= (state_q == st_done) ? 2'(mode_seq_pkg::op_halt) : cur.mode;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         boot_option_out <= `BOOT_OPTION; // [R10]
         fast_osc_mhz_out <= 6'(`FAST_OSC_MHZ); // [R8]
      end
      else
      begin
         boot_option_out <= `BOOT_OPTION;
         fast_osc_mhz_out <= 6'(`FAST_OSC_MHZ);
      end
   end
endmodule
`default_nettype wire

/* logic/mode_seq_cfg.svh */
// What this block does
// R1 - one step per confirmed switch falling edge
// R2 - sample every 5ms, two equal samples
// R3 - normal mode LED patterns per clock source
// R4 - halt, stop, snooze clear LED bits
// R5 - after step 31, LEDs off, halt forever
// R6 - clock switch timeout: LEDs off, error stop
// R7 - one switch input, five LED outputs
// R8 - start on fast internal oscillator, 24 MHz
// R9 - falling edge detection enabled at init
// R10 - watchdog stopped, boot value 01101110B
// R11 - unconfirmed edges change nothing
`ifndef MODE_SEQ_CFG_SVH
`define MODE_SEQ_CFG_SVH
`define CLK_FREQ_HZ 100000000
`define SAMPLE_PERIOD_MS 5
`define SAMPLE_CYCLES (`CLK_FREQ_HZ / 1000 * `SAMPLE_PERIOD_MS)
`define STEP_COUNT 31
`define FAST_OSC_MHZ 24
`define BOOT_OPTION 8'h6e
`define SWITCH_TIMEOUT_TICKS 8'h14
`define LED_RESET 5'h00
`endif

/* logic/mode_seq_pkg.sv */
package mode_seq_pkg;
   typedef enum logic [1:0] {src_fast, src_xtal, src_mid, src_low} clk_src_t;
   typedef enum logic [1:0] {op_normal, op_halt, op_stop, op_snooze} op_mode_t;
   typedef struct packed
   {
      clk_src_t src;
      op_mode_t mode;
   } step_t;
endpackage

/* sim/mode_seq_ref_pkg.sv */
`default_nettype none
package mode_seq_ref_pkg;
   // clock source and mode digit per step row
   localparam string SRC_ROW = "0111110000000213122222223203330";
   localparam string MODE_ROW = "0010200102030000001020300000100";
   function automatic logic [4:0] led_pat(input logic [1:0] s, input logic [1:0] m);
      logic [4:0] p;
      p = (s == 2'h0) ? 5'h13 : (s == 2'h1) ? 5'h17 : (s == 2'h2) ? 5'h0b : 5'h1b;
      return p & ((m == 2'h1) ? 5'h1e : (m == 2'h2) ? 5'h1c : (m == 2'h3) ? 5'h1d : 5'h1f);
   endfunction
   function automatic logic [4:0] row_pat(input int r);
      return led_pat(2'(SRC_ROW[r] - 8'h30), 2'(MODE_ROW[r] - 8'h30));
   endfunction
endpackage
`default_nettype wire

/* sim/push_switch_model.sv */
`timescale 1ns/1ps
`default_nettype none
module push_switch_model
(
   input wire logic clk_in,
   input wire logic press_in,
   output logic switch_input_pin_out
);
   logic [1:0] bounce_q = 2'h0;
   logic last_q = 1'b0;
   logic pin_q = 1'b1;
   assign switch_input_pin_out = pin_q;
   // contacts chatter two cycles, pull-up when open
   always @(posedge clk_in)
   begin
      bounce_q <= (press_in != last_q) ? 2'h2 : (bounce_q != 2'h0) ? bounce_q - 2'h1 : 2'h0;
      last_q <= press_in;
      pin_q <= (bounce_q != 2'h0) ? ~pin_q : ~last_q;
   end
endmodule
`default_nettype wire

/* sim/mode_seq_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module mode_seq_checker
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic xtal_ready_in,
   input wire logic [4:0] led_out,
   input wire logic error_out,
   input wire logic done_halt_out,
   input wire logic [7:0] boot_option_out,
   input wire logic [5:0] fast_osc_mhz_out,
   input wire logic [1:0] clk_src_out,
   input wire logic [1:0] op_mode_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   logic [1:0] quiet_q;
   // cycles (up to 3) since source or mode last moved or xtal_ready_in was low
   always_ff @(posedge clk_in or negedge nrst_in)
      if (!nrst_in)
         quiet_q <= 2'h0;
      else if ($changed(clk_src_out) || $changed(op_mode_out) || !xtal_ready_in)
         quiet_q <= 2'h0;
      else if (quiet_q != 2'h3)
         quiet_q <= quiet_q + 2'h1;
   sequence s_halted;
      done_halt_out && led_out == 5'h00 && op_mode_out == 2'h1;
   endsequence
   AST_BOOT: assert property (boot_option_out == 8'h6e) else $error("boot value wrong");
   AST_OSC: assert property (fast_osc_mhz_out == 6'h18) else $error("osc value wrong");
   AST_PATTERN: assert property (quiet_q >= 2'h2 && !done_halt_out && !error_out |->
      led_out == mode_seq_ref_pkg::led_pat(clk_src_out, op_mode_out)) else $error("led pattern wrong");
   AST_DONE_IN: assert property ($rose(done_halt_out) |-> ##[0:1] s_halted) else $error("halt entry wrong");
   AST_DONE_HOLD: assert property (done_halt_out |=> s_halted [*2]) else $error("halt left");
   AST_DONE_NOERR: assert property (done_halt_out |=> !error_out) else $error("error after halt");
   AST_ERR_HOLD: assert property (error_out |=> error_out && led_out == 5'h00) else $error("error left");
   AST_ERR_FROZEN: assert property (error_out |=> $stable(clk_src_out) && $stable(op_mode_out))
      else $error("stepping after error");
endmodule
`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk_in, nrst_in, press, xtal_ready_in, switch_input_pin_in, error_out, done_halt_out;
   logic [4:0] led_out, prev_led;
   logic [7:0] boot_option_out;
   logic [5:0] fast_osc_mhz_out;
   logic [1:0] clk_src_out, op_mode_out;
   logic [4:0] exp_q[$];
   int n_mismatch = 0;
   int check_count = 0;
   int seed = 32'h515417ce;
   switch_mode_sequencer_leds #(.SAMPLE_CYCLES(4), .TIMEOUT_TICKS(8'h03)) DUT (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .switch_input_pin_in(switch_input_pin_in),
      .xtal_ready_in(xtal_ready_in),
      .led_out(led_out),
      .error_out(error_out),
      .done_halt_out(done_halt_out),
      .boot_option_out(boot_option_out),
      .fast_osc_mhz_out(fast_osc_mhz_out),
      .clk_src_out(clk_src_out),
      .op_mode_out(op_mode_out)
   );
   push_switch_model sw_model (.clk_in(clk_in), .press_in(press), .switch_input_pin_out(switch_input_pin_in));
   initial
   begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
      check_count++;
      if (seen !== want)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic tally_and_finish();
      if (n_mismatch == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic press_for(input int n);
      press = 1'b1;
      cyc(n);
      press = 1'b0;
      cyc(n);
   endtask
   task automatic do_reset();
      nrst_in = 1'b0;
      cyc(4);
      exp_q.push_back(5'h13);
      nrst_in = 1'b1;
   endtask
   // each led change takes the oldest note
   always @(negedge clk_in)
      if (!nrst_in)
         prev_led = led_out;
      else if (led_out !== prev_led)
      begin
         check(8'(led_out), exp_q.size() > 0 ? 8'(exp_q.pop_front()) : 8'hff, "led");
         prev_led = led_out;
      end
   initial
   begin
      press = 1'b0;
      xtal_ready_in = 1'b1;
      do_reset();
      cyc(8);
      check(boot_option_out, 8'h6e, "boot");
      check(8'(fast_osc_mhz_out), 8'h18, "osc");
      press = 1'b1;
      cyc(1);
      press = 1'b0;
      cyc(24);
      for (int i = 1; i < 31; i++)
      begin
         exp_q.push_back(mode_seq_ref_pkg::row_pat(i));
         press_for(20 + ($random(seed) & 7));
      end
      exp_q.push_back(5'h00);
      press_for(20);
      check(8'(op_mode_out), 8'h01, "mode");
      press_for(20);
      check(8'(done_halt_out), 8'h01, "done");
      check(8'(clk_src_out), 8'h00, "source");
      xtal_ready_in = 1'b0;
      do_reset();
      exp_q.push_back(5'h00);
      press_for(24);
      check(8'(error_out), 8'h01, "error");
      press_for(24);
      check(8'(exp_q.size()), 8'h00, "pending");
      tally_and_finish();
   end
   initial
   begin
      repeat (20000) @(posedge clk_in);
      n_mismatch++;
      tally_and_finish();
   end
endmodule
bind switch_mode_sequencer_leds mode_seq_checker chk (
   .clk_in(clk_in),
   .nrst_in(nrst_in),
   .xtal_ready_in(xtal_ready_in),
   .led_out(led_out),
   .error_out(error_out),
   .done_halt_out(done_halt_out),
   .boot_option_out(boot_option_out),
   .fast_osc_mhz_out(fast_osc_mhz_out),
   .clk_src_out(clk_src_out),
   .op_mode_out(op_mode_out)
);
`default_nettype wire
